// ---- verilog/dvr_tx.sv ----
// Added by the designer: the address map and the address-and-strobe port.
module dvr_tx
  import dvr_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  dvr_link_if.host lnk,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out
);
  logic run_r;
  logic [7:0] half_r;
  logic [7:0] mhz_r;
  logic [1:0] lane_code_r;
  logic param_err_r;
  logic underrun_r;
  logic pend_r;
  logic [7:0] type_r;
  logic [7:0] beats_r;
  logic [31:0] data_r;
  logic full_r;
  logic [2:0] a_r;
  logic ack;
  logic [7:0] div_r;
  logic clk_r;
  logic fall;
  dvr_tx_st_t st_r;
  logic [7:0] cnt_r;
  logic [2:0] bit_r;
  logic hs_r;
  logic [3:0] dat_r;
  logic [3:0][7:0] sh_r;
  logic take;
  logic wr_param;
  logic param_bad;

  assign wr_param = reg_wr_in && (reg_addr_in == REG_PARAM);
  // new rate only through BDh, only while idle
  assign param_bad = (reg_wdata_in[31:24] != OP_LINK_PARAM) || (st_r != TX_IDLE)
    || !mhz_ok(reg_wdata_in[15:8]) || (reg_wdata_in[7:0] == 8'h00);
  // first payload loads as the header's last bit leaves, so no idle beat between them
  assign take = ((st_r == TX_HEAD) || (st_r == TX_BODY)) && fall && (bit_r == 3'h7)
    && (beats_r != 8'h00);

  // link setup travels on this port, never on the lanes
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      run_r <= 1'b0;
      half_r <= HALF_RST;
      mhz_r <= MHZ_RST;
      lane_code_r <= LANE_RST;
      param_err_r <= 1'b0;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == REG_CTRL)
      begin
        run_r <= reg_wdata_in[0];
      end
      // divider frozen outside a parameter write
      if (wr_param && !param_bad)
      begin
        lane_code_r <= reg_wdata_in[17:16];
        mhz_r <= reg_wdata_in[15:8];
        half_r <= reg_wdata_in[7:0];
      end
      if (wr_param && param_bad)
      begin
        param_err_r <= 1'b1;
      end
      else if (reg_wr_in && reg_addr_in == REG_CTRL && reg_wdata_in[1])
      begin
        param_err_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pend_r <= 1'b0;
      type_r <= 8'h00;
      beats_r <= 8'h00;
      data_r <= 32'h0000_0000;
      full_r <= 1'b0;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == REG_PKT && st_r == TX_IDLE)
      begin
        pend_r <= 1'b1;
        type_r <= reg_wdata_in[7:0];
        beats_r <= reg_wdata_in[15:8];
      end
      else if (st_r == TX_ZERO)
      begin
        pend_r <= 1'b0;
      end
      else if (take)
      begin
        beats_r <= beats_r - 8'h01;
      end
      // a new word written in the same cycle wins over consumption
      if (reg_wr_in && reg_addr_in == REG_DATA)
      begin
        data_r <= reg_wdata_in;
        full_r <= 1'b1;
      end
      else if (take)
      begin
        full_r <= 1'b0;
      end
    end
  end

  // device ack crosses domains: three flops, stages two and three agree
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      a_r <= 3'h0;
      ack <= 1'b0;
    end
    else
    begin
      a_r <= {a_r[1:0], lnk.dev_ack};
      ack <= (a_r[1] & a_r[2]) | (ack & (a_r[1] | a_r[2]));
    end
  end

  // link clock from the system clock by a divider whose half period half_r is set through the parameter register
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      div_r <= 8'h00;
      clk_r <= 1'b0;
    end
    else if (!run_r)
    begin
      div_r <= 8'h00;
      clk_r <= 1'b0;
    end
    else if (div_r == half_r - 8'h01)
    begin
      div_r <= 8'h00;
      clk_r <= ~clk_r;
    end
    else
    begin
      div_r <= div_r + 8'h01;
    end
  end

  assign fall = clk_r && (div_r == half_r - 8'h01);

  // request raised only after software starts us
  // lanes driven by this end only, no turnaround
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_r <= TX_IDLE;
      cnt_r <= 8'h00;
      bit_r <= 3'h0;
      hs_r <= 1'b0;
      dat_r <= 4'h0;
      sh_r <= '0;
      underrun_r <= 1'b0;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == REG_CTRL && reg_wdata_in[1])
      begin
        underrun_r <= 1'b0;
      end
      if (take && !full_r)
      begin
        underrun_r <= 1'b1;
      end
      if (fall && st_r != TX_IDLE && st_r != TX_ZERO)
      begin
        for (int l = 0; l < 4; l++)
        begin
          dat_r[l] <= (3'(l) < lane_count(lane_code_r)) ? sh_r[l][0] : 1'b0;
          sh_r[l] <= {1'b0, sh_r[l][7:1]};
        end
        bit_r <= bit_r + 3'h1;
      end
      unique case (st_r)
        TX_IDLE:
        begin
          if (pend_r && ack && run_r)
          begin
            st_r <= TX_ZERO;
            hs_r <= 1'b1;
            dat_r <= 4'h0;
            cnt_r <= hszero_cyc(mhz_r);
          end
        end
        // HS-0 held for the least prepare time
        TX_ZERO:
        begin
          if (cnt_r != 8'h00)
          begin
            cnt_r <= cnt_r - 8'h01;
          end
          else if (fall)
          begin
            st_r <= TX_SYNC;
            bit_r <= 3'h1;
            dat_r <= {4{SYNC_BYTE[0]}};
            sh_r <= {4{1'b0, SYNC_BYTE[7:1]}};
          end
        end
        TX_SYNC:
        begin
          if (fall && bit_r == 3'h7)
          begin
            st_r <= TX_HEAD;
            sh_r <= {24'h00_0000, type_r};
          end
        end
        TX_HEAD:
        begin
          if (take)
          begin
            st_r <= TX_BODY;
            sh_r <= full_r ? data_r : 32'h0000_0000;
          end
          else if (fall && bit_r == 3'h7)
          begin
            st_r <= TX_END;
          end
        end
        TX_BODY:
        begin
          if (take)
          begin
            sh_r <= full_r ? data_r : 32'h0000_0000;
          end
          else if (fall && bit_r == 3'h7)
          begin
            st_r <= TX_END;
          end
        end
        TX_END:
        begin
          if (fall)
          begin
            st_r <= TX_IDLE;
            hs_r <= 1'b0;
            dat_r <= 4'h0;
          end
        end
        default:
        begin
          st_r <= TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      reg_rdata_out <= 32'h0000_0000;
    end
    else if (!reg_rd_in)
    begin
      reg_rdata_out <= 32'h0000_0000;
    end
    else
    begin
      unique case (reg_addr_in)
        REG_CTRL: reg_rdata_out <= {31'h0000_0000, run_r};
        REG_PARAM: reg_rdata_out <= {14'h0000, lane_code_r, mhz_r, half_r};
        REG_STAT: reg_rdata_out <= {26'h000_0000, underrun_r, pend_r, param_err_r,
          full_r, st_r != TX_IDLE, ack};
        REG_PKT: reg_rdata_out <= {16'h0000, beats_r, type_r};
        REG_DATA: reg_rdata_out <= data_r;
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
    end
  end

  assign lnk.lnk_clk = clk_r;
  assign lnk.lnk_hs = hs_r;
  assign lnk.lnk_data = dat_r;
  assign lnk.host_req = run_r;
endmodule // dvr_tx

// ---- verilog/dvr_pkg.sv ----
package dvr_pkg;
  localparam int CLK_NS = 4;
  localparam int PREP_SLOW_NS = 565;
  localparam int PREP_FAST_NS = 465;
  // least time rounds up, longest time rounds down
  localparam int HSZERO_SLOW_CYC = (PREP_SLOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HSZERO_FAST_CYC = (PREP_FAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_SLOW_CYC = PREP_SLOW_NS / CLK_NS;
  localparam int SETTLE_FAST_CYC = PREP_FAST_NS / CLK_NS;
  localparam logic [7:0] MHZ_MIN = 8'h50;
  localparam logic [7:0] MHZ_SLOW_MAX = 8'h5e;
  localparam logic [7:0] MHZ_MAX = 8'heb;
  localparam logic [7:0] SYNC_BYTE = 8'hb8;
  localparam logic [7:0] OP_LINK_PARAM = 8'hbd;
  localparam logic [7:0] HALF_RST = 8'h08;
  localparam logic [7:0] MHZ_RST = 8'h50;
  localparam logic [1:0] LANE_RST = 2'h0;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PARAM = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_PKT = 8'h0c;
  localparam logic [7:0] REG_DATA = 8'h10;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_SETTLE = 2'b01,
    RX_HUNT = 2'b10,
    RX_DATA = 2'b11
  } dvr_rx_st_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_ZERO = 3'b001,
    TX_SYNC = 3'b010,
    TX_HEAD = 3'b011,
    TX_BODY = 3'b100,
    TX_END = 3'b101
  } dvr_tx_st_t;

  function automatic logic [2:0] lane_count(input logic [1:0] code);
    lane_count = {1'b0, code} + 3'h1;
  endfunction

  function automatic logic mhz_ok(input logic [7:0] mhz);
    mhz_ok = (mhz >= MHZ_MIN) && (mhz <= MHZ_MAX);
  endfunction

  function automatic logic [7:0] settle_cyc(input logic [7:0] mhz);
    settle_cyc = (mhz <= MHZ_SLOW_MAX) ? 8'(SETTLE_SLOW_CYC) : 8'(SETTLE_FAST_CYC);
  endfunction

  function automatic logic [7:0] hszero_cyc(input logic [7:0] mhz);
    hszero_cyc = (mhz <= MHZ_SLOW_MAX) ? 8'(HSZERO_SLOW_CYC) : 8'(HSZERO_FAST_CYC);
  endfunction

  // packed pixel stream types share the low nibble
  function automatic logic is_video(input logic [7:0] dt);
    is_video = (dt[3:0] == 4'he);
  endfunction
endpackage

// ---- verilog/dvr_link_if.sv ----
interface dvr_link_if;
  logic lnk_clk;
  logic lnk_hs;
  logic [3:0] lnk_data;
  logic host_req;
  logic dev_ack;
  modport dev (input lnk_clk, lnk_hs, lnk_data, host_req, output dev_ack);
  modport host (output lnk_clk, lnk_hs, lnk_data, host_req, input dev_ack);
endinterface

// ---- verilog/dvr_rx.sv ----
module dvr_rx
  import dvr_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  dvr_link_if.dev lnk,
  input wire logic dsi_sel_in,
  input wire logic [1:0] lane_code_in,
  input wire logic boot_done_in,
  input wire logic [7:0] hs_clk_mhz_in,
  input wire logic rgb_valid_in,
  input wire logic [23:0] rgb_data_in,
  output logic pix_valid_out,
  output logic [31:0] pix_data_out,
  output logic [2:0] pix_bytes_out,
  output logic link_up_out,
  output logic missed_out,
  output logic rate_err_out,
  output logic [2:0] lanes_out,
  output logic cmd_drop_out
);
  logic straps_done_r;
  logic dsi_mode_r;
  logic [1:0] lane_code_r;
  logic [6:0] raw;
  logic [6:0] s1_r;
  logic [6:0] s2_r;
  logic [6:0] s3_r;
  logic [6:0] filt_r;
  logic clk_d_r;
  logic hs_d_r;
  logic req_d_r;
  logic ready;
  logic ready_d_r;
  logic link_r;
  logic missed_r;
  logic rate_err_r;
  logic clk_rise;
  logic hs_rise;
  logic hs_fall;
  logic req_rise;
  dvr_rx_st_t st_r;
  logic [7:0] settle_r;
  logic [2:0] bit_r;
  logic first_r;
  logic video_r;
  logic [3:0][7:0] sh_r;
  logic [3:0][7:0] sh_nxt;
  logic [31:0] beat_word;
  logic [2:0] lanes;
  logic beat_done;

  assign raw = {lnk.host_req, lnk.lnk_data, lnk.lnk_hs, lnk.lnk_clk};
  assign lanes = lane_count(lane_code_r);

  // straps sampled once after reset release, then frozen
  // DSI select and lane code straps
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      straps_done_r <= 1'b0;
      dsi_mode_r <= 1'b0;
      lane_code_r <= LANE_RST;
    end
    else if (!straps_done_r)
    begin
      straps_done_r <= 1'b1;
      dsi_mode_r <= dsi_sel_in;
      lane_code_r <= lane_code_in;
    end
  end

  // three-stage sync; a change counts once stages two and three agree
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      filt_r <= '0;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      clk_d_r <= 1'b0;
      hs_d_r <= 1'b0;
      req_d_r <= 1'b0;
      ready_d_r <= 1'b0;
    end
    else
    begin
      clk_d_r <= filt_r[0];
      hs_d_r <= filt_r[1];
      req_d_r <= filt_r[6];
      ready_d_r <= ready;
    end
  end

  assign clk_rise = filt_r[0] & ~clk_d_r;
  assign hs_rise = filt_r[1] & ~hs_d_r;
  assign hs_fall = ~filt_r[1] & hs_d_r;
  assign req_rise = filt_r[6] & ~req_d_r;

  // DSI path only when strap picks it
  assign ready = straps_done_r & dsi_mode_r & boot_done_in;

  // host request must rise after we are ready
  // request already high at readiness is lost for good
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      link_r <= 1'b0;
      missed_r <= 1'b0;
    end
    else if (ready && !ready_d_r && filt_r[6])
    begin
      missed_r <= 1'b1;
    end
    else if (ready && ready_d_r && req_rise && !missed_r)
    begin
      link_r <= 1'b1;
    end
  end

  assign lnk.dev_ack = link_r;

  // flag clock settings outside the MHZ_MIN to MHZ_MAX range while the DSI path is ready
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rate_err_r <= 1'b0;
    end
    else
    begin
      rate_err_r <= ready & ~mhz_ok(hs_clk_mhz_in);
    end
  end

  always_comb
  begin
    for (int l = 0; l < 4; l++)
    begin
      sh_nxt[l] = {filt_r[2 + l], sh_r[l][7:1]};
    end
  end

  // inactive lanes read as zero so a narrow link never leaks stale bits
  always_comb
  begin
    beat_word = '0;
    for (int l = 0; l < 4; l++)
    begin
      if (3'(l) < lanes)
      begin
        beat_word[8 * l +: 8] = sh_nxt[l];
      end
    end
  end

  assign beat_done = (st_r == RX_DATA) && clk_rise && (bit_r == 3'h7);

  // lanes are only ever received, never driven back
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_r <= RX_IDLE;
      settle_r <= '0;
      bit_r <= '0;
      first_r <= 1'b0;
      sh_r <= '0;
    end
    else if (hs_fall || !link_r)
    begin
      st_r <= RX_IDLE;
    end
    else
    begin
      unique case (st_r)
        RX_IDLE:
        begin
          if (hs_rise)
          begin
            st_r <= RX_SETTLE;
            settle_r <= settle_cyc(hs_clk_mhz_in);
          end
        end
        RX_SETTLE:
        begin
          sh_r <= '0;
          if (settle_r == 8'h00)
          begin
            st_r <= RX_HUNT;
          end
          else
          begin
            settle_r <= settle_r - 8'h01;
          end
        end
        RX_HUNT:
        begin
          if (clk_rise)
          begin
            sh_r <= sh_nxt;
            if (sh_nxt[0] == SYNC_BYTE)
            begin
              st_r <= RX_DATA;
              bit_r <= '0;
              first_r <= 1'b1;
            end
          end
        end
        RX_DATA:
        begin
          if (clk_rise)
          begin
            sh_r <= sh_nxt;
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7)
            begin
              first_r <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // header byte on lane 0 decides whether the burst is kept
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      video_r <= 1'b0;
      cmd_drop_out <= 1'b0;
    end
    else
    begin
      cmd_drop_out <= beat_done & first_r & ~is_video(sh_nxt[0]);
      if (beat_done && first_r)
      begin
        video_r <= is_video(sh_nxt[0]);
      end
    end
  end

  // one source feeds the pixel output
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pix_valid_out <= 1'b0;
      pix_data_out <= 32'h0000_0000;
      pix_bytes_out <= 3'h0;
    end
    else if (!dsi_mode_r)
    begin
      pix_valid_out <= straps_done_r & rgb_valid_in;
      pix_data_out <= {8'h00, rgb_data_in};
      pix_bytes_out <= 3'h3;
    end
    else
    begin
      // only video beats leave the block
      pix_valid_out <= beat_done & ~first_r & video_r;
      pix_data_out <= beat_word;
      pix_bytes_out <= lanes;
    end
  end

  assign link_up_out = link_r;
  assign missed_out = missed_r;
  assign rate_err_out = rate_err_r;
  assign lanes_out = lanes;
endmodule // dvr_rx

// ---- bench/dvr_link_sva.sv ----
module dvr_link_sva
  import dvr_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic lnk_clk,
  input wire logic lnk_hs,
  input wire logic [3:0] lnk_data,
  input wire logic host_req,
  input wire logic dev_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] zcnt_r;
  // cycles since burst start, saturating
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in) zcnt_r <= 8'h00;
    else if (!lnk_hs) zcnt_r <= 8'h00;
    else if (zcnt_r != 8'hff) zcnt_r <= zcnt_r + 8'h01;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_ack_req; $rose(dev_ack) |-> host_req; endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack without request");
  property p_ack_time; $rose(host_req) |-> ##[2:16] dev_ack; endproperty
  a_ack_time: assert property (p_ack_time) else $error("ack late");
  property p_hs_zero; $rose(lnk_hs) |-> lnk_data == 4'h0; endproperty
  a_hs_zero: assert property (p_hs_zero) else $error("burst not at zero");
  property p_zero_len; lnk_hs && lnk_data != 4'h0 |-> zcnt_r >= 8'(HSZERO_FAST_CYC); endproperty
  a_zero_len: assert property (p_zero_len) else $error("zero state short");
  property p_burst_up; lnk_hs |-> dev_ack && host_req; endproperty
  a_burst_up: assert property (p_burst_up) else $error("burst without link");
  property p_data_hold; lnk_hs && lnk_clk && $past(lnk_clk) |-> $stable(lnk_data); endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved in high");
  property p_clk_still; !host_req && !$past(host_req) |-> $stable(lnk_clk); endproperty
  a_clk_still: assert property (p_clk_still) else $error("clock runs idle");
  property p_half; $rose(lnk_clk) |-> lnk_clk [*8] ##1 !lnk_clk; endproperty
  a_half: assert property (p_half) else $error("clock half wrong");
endmodule // dvr_link_sva

// ---- bench/tb.sv ----
module tb;
  import dvr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, resetn_in, wr, rd, dsi_sel, boot, boot2, rgb_v, pix_v, link_up, missed2;
  logic rate_err, cmd_drop, missed;
  logic [7:0] addr, mhz;
  logic [31:0] wdata, rdata, pix_d, d, m;
  logic [23:0] rgb_d;
  logic [1:0] lcode;
  logic [2:0] pix_b, lanes, pixb;
  logic [31:0] pixq[$];
  int miscompares, num_checks, drops, i;
  dvr_link_if lnk();
  dvr_link_if lnk2();
  dvr_tx u_dvr_tx (.clk_in(clk_in), .resetn_in(resetn_in), .lnk(lnk.host), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata));
  dvr_rx u_dvr_rx (.clk_in(clk_in), .resetn_in(resetn_in), .lnk(lnk.dev), .dsi_sel_in(dsi_sel),
    .lane_code_in(lcode), .boot_done_in(boot), .hs_clk_mhz_in(mhz), .rgb_valid_in(rgb_v),
    .rgb_data_in(rgb_d), .pix_valid_out(pix_v), .pix_data_out(pix_d), .pix_bytes_out(pix_b),
    .link_up_out(link_up), .missed_out(missed), .rate_err_out(rate_err), .lanes_out(lanes),
    .cmd_drop_out(cmd_drop));
  // far end driven by the bench: request up before boot
  dvr_rx u_dvr_rx2 (.clk_in(clk_in), .resetn_in(resetn_in), .lnk(lnk2.dev), .dsi_sel_in(1'b1),
    .lane_code_in(2'h0), .boot_done_in(boot2), .hs_clk_mhz_in(mhz), .rgb_valid_in(1'b0),
    .rgb_data_in(24'h00_0000), .pix_valid_out(), .pix_data_out(), .pix_bytes_out(),
    .link_up_out(), .missed_out(missed2), .rate_err_out(), .lanes_out(), .cmd_drop_out());
  dvr_link_sva u_dvr_link_sva (.clk_in(clk_in), .resetn_in(resetn_in), .lnk_clk(lnk.lnk_clk),
    .lnk_hs(lnk.lnk_hs), .lnk_data(lnk.lnk_data), .host_req(lnk.host_req),
    .dev_ack(lnk.dev_ack));
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    if (pix_v === 1'b1)
    begin
      pixq.push_back(pix_d);
      pixb = pix_b;
    end
    if (cmd_drop === 1'b1) drops++;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // poll status until the given bits clear
  task automatic wait_clr(input logic [31:0] bits);
    for (int k = 0; k < 2000; k++)
    begin
      rd_reg(REG_STAT, d);
      if ((d & bits) == 32'h0000_0000) break;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    {wr, rd, rgb_v, boot2} = 4'h0;
    {resetn_in, dsi_sel, boot} = 3'b011;
    {addr, wdata, rgb_d, lcode, mhz} = {8'h00, 32'h0, 24'h5a_5a5a, 2'h0, 8'h50};
    {lnk2.lnk_clk, lnk2.lnk_hs, lnk2.lnk_data, lnk2.host_req} = 7'b000_0001;
    for (int l = 0; l < 4; l++)
    begin
      lcode <= 2'(l);
      mhz <= (l == 0) ? 8'h50 : 8'h64;
      dsi_sel <= 1'b1;
      resetn_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      resetn_in <= 1'b1;
      // straps land at the first edge; read them one edge later
      repeat (2) @(posedge clk_in);
      pixq.delete();
      drops = 0;
      m = 32'hffff_ffff >> (8 * (3 - l));
      chk("lanes", 32'(lanes), l + 1);
      wr_reg(REG_PARAM, {8'h12, 6'h0, lcode, mhz, HALF_RST});
      rd_reg(REG_STAT, d);
      chk("bad_opcode", d[3], 1);
      wr_reg(REG_CTRL, 32'h0000_0002);
      wr_reg(REG_PARAM, {OP_LINK_PARAM, 6'h0, lcode, 8'hec, HALF_RST});
      rd_reg(REG_STAT, d);
      chk("bad_mhz", d[3], 1);
      wr_reg(REG_CTRL, 32'h0000_0002);
      wr_reg(REG_PARAM, {OP_LINK_PARAM, 6'h0, lcode, mhz, HALF_RST});
      rd_reg(REG_STAT, d);
      chk("good_param", d[3], 0);
      rd_reg(REG_PARAM, d);
      chk("param_rb", d, {14'h0000, lcode, mhz, HALF_RST});
      wr_reg(REG_CTRL, 32'h0000_0001);
      for (i = 0; i < 50 && lnk.dev_ack !== 1'b1; i++) @(posedge clk_in);
      chk("link_up", link_up, 1);
      chk("no_missed", missed, 0);
      // strap flip while running must not change source
      dsi_sel <= 1'b0;
      rgb_v <= 1'b1;
      @(posedge clk_in);
      rgb_v <= 1'b0;
      wr_reg(REG_PKT, 32'h0000_023e);
      wr_reg(REG_DATA, 32'h1234_56a7);
      wait_clr(32'h0000_0004);
      wr_reg(REG_DATA, 32'hc3e1_5a0f);
      wait_clr(32'h0000_0012);
      for (i = 0; i < 500 && pixq.size() < 2; i++) @(posedge clk_in);
      chk("pix_count", pixq.size(), 2);
      chk("pix0", pixq[0], 32'h1234_56a7 & m);
      chk("pix1", pixq[1], 32'hc3e1_5a0f & m);
      chk("pix_bytes", 32'(pixb), l + 1);
      wr_reg(REG_PKT, 32'h0000_0105);
      wr_reg(REG_DATA, 32'hffff_ffff);
      wait_clr(32'h0000_0012);
      repeat (300) @(posedge clk_in);
      chk("cmd_drop", drops, 1);
      chk("cmd_no_pix", pixq.size(), 2);
      $display("lane code %0d test done", l);
    end
    mhz <= 8'h4f;
    repeat (4) @(posedge clk_in);
    chk("rate_low", rate_err, 1);
    mhz <= 8'heb;
    repeat (4) @(posedge clk_in);
    chk("rate_top", rate_err, 0);
    $display("rate test done");
    // parallel source picked by strap; a later flip must not switch it
    dsi_sel <= 1'b0;
    resetn_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    pixq.delete();
    dsi_sel <= 1'b1;
    rgb_v <= 1'b1;
    @(posedge clk_in);
    rgb_v <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("rgb_count", pixq.size(), 1);
    chk("rgb_pix", pixq[0], 32'h005a_5a5a);
    chk("rgb_bytes", 32'(pixb), 3);
    $display("rgb test done");
    boot2 <= 1'b1;
    repeat (40) @(posedge clk_in);
    chk("missed", missed2, 1);
    chk("no_ack", lnk2.dev_ack, 0);
    $display("late boot test done");
    tally_and_finish();
  end
endmodule // tb
